// ==== common/gcp_pkg.sv ====
// package: constants shared by the command string parser
package gcp_pkg;
    // ==========================================================
    // characters on the data lines
    localparam logic [7:0] CH_RUN   = 8'h58;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_NINE  = 8'h39;

    // ==========================================================
    // command letters, index = execution priority (0 runs first)
    localparam int NCMD = 15;
    localparam logic [NCMD-1:0][7:0] CMD_CHAR = {8'h59, 8'h4F, 8'h47, 8'h56, 8'h4C,
        8'h41, 8'h4D, 8'h4B, 8'h55, 8'h4A, 8'h57, 8'h43, 8'h5A, 8'h52, 8'h46};
    // highest legal option per letter (gate letter checked as a set)
    localparam logic [NCMD-1:0][7:0] OPT_MAX = {8'h04, 8'h01, 8'h01, 8'h00, 8'h00,
        8'h00, 8'h20, 8'h01, 8'h02, 8'h00, 8'h01, 8'h01, 8'h01, 8'h0C, 8'h07};
    localparam logic [3:0] IX_SRC  = 4'h0;
    localparam logic [3:0] IX_SPAN = 4'h1;
    localparam logic [3:0] IX_SELF = 4'h5;
    localparam logic [3:0] IX_RPT  = 4'h6;
    localparam logic [3:0] IX_GATE = 4'h8;
    localparam logic [3:0] IX_CAL  = 4'h9;
    localparam logic [3:0] IX_LCAL = 4'hA;
    localparam logic [3:0] IX_OUT  = 4'hB;
    localparam logic [3:0] IX_LAST = 4'hE;
    localparam logic [3:0] IX_NONE = 4'hF;

    // ==========================================================
    // power-up settings and service gate values
    localparam logic [15:0] DEF_SET   = 16'h0000;
    localparam logic [15:0] GATE_DONE = 16'h0002;
    localparam logic [15:0] GATE_RDY  = 16'h0010;
    localparam logic [15:0] GATE_ERR  = 16'h0020;

    // ==========================================================
    // status byte bit positions
    localparam int SB_RQS = 6;
    localparam int SB_ERR = 5;
    localparam int SB_RDY = 4;
endpackage

// ==== logic/gcp_parser.sv ====
// design: command byte fifo and the command string parser top
//
// Behaviour
// - selective clear restores all power-up defaults
// - poll mode, talker, ATN false: drive status
// - several devices polled within one poll mode
// - poll answered whether or not service requested
// - command is letter then decimal option
// - command bytes taken only with ATN false
// - buffered until run character, then executed
// - execution follows fixed priority order
// - repeated letter: last occurrence wins
// - spaces discarded without error
// - bad letter, option or REN false: ignore
// - REN false also raises bus error
// - command error flags, SRQ when gate allows
// - source kind options 0 to 7 only
// - letters outside command set rejected
// - report option selects next talk content
// - low temperature trim value applied
// - output set point value programs source
// - bad value drops only that command
// - REN alone does not make remote
`timescale 1ns/100ps

// ==========================================================
// fifo for received command bytes
module gcp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic [AW:0]      next_cnt;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rp];

    // occupancy
    always_comb begin
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    // pointers and flags, all registered
    always_ff @(posedge sys_clk) begin
        if (reset || flush) begin
            wp        <= '0;
            rp        <= '0;
            cnt       <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            cnt       <= next_cnt;
            in_ready  <= next_cnt != (AW+1)'(DEPTH);
            out_valid <= next_cnt != '0;
        end
    end

    // storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule

// ==========================================================
// command string parser and clear/poll responder
module gcp_parser #(
    parameter logic [15:0] CAL_MAX = 16'h270F,
    parameter logic [15:0] OUT_MAX = 16'h270F
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // bus state from the interface function
    input  wire logic        atn,
    input  wire logic        ren,
    input  wire logic        listen_addr,
    input  wire logic        talk_addr,
    input  wire logic        sdc_cmd,
    input  wire logic        spe_cmd,
    input  wire logic        spd_cmd,
    // received data bytes
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    output logic             rx_ready,
    // status byte onto the data lines
    output logic [7:0]       dio_out,
    output logic             dio_oe,
    output logic             srq,
    input  wire logic        charge_done,
    // settings
    output logic [2:0]       src_kind,
    output logic [3:0]       span_sel,
    output logic             null_on,
    output logic             temp_adj,
    output logic             shield_on,
    output logic             self_test,
    output logic [1:0]       report_sel,
    output logic             end_flag_off,
    output logic [5:0]       srq_gate,
    output logic [15:0]      cal_value,
    output logic [15:0]      low_cal_value,
    output logic [15:0]      set_point,
    output logic             prefix_off,
    output logic             arm_on,
    output logic [2:0]       line_end,
    // indications
    output logic             remote,
    output logic             unknown_command_letter,
    output logic             invalid_command_option,
    output logic             number_err,
    output logic             bus_err,
    output logic             exec_done
);
    typedef enum logic [0:0] {ST_RX, ST_EXEC} gcp_state_t;

    gcp_state_t  st;
    logic [3:0]  step;
    logic [15:0] set_reg [gcp_pkg::NCMD];
    logic [15:0] pend    [gcp_pkg::NCMD];
    logic [gcp_pkg::NCMD-1:0] pend_v;
    logic [3:0]  cur;
    logic [15:0] acc;
    logic        got_dig;
    logic        ovf;
    logic        bad_let;
    logic        bad_opt;
    logic        bad_num;
    logic        ren_bad;
    logic        spoll;
    logic        err_flag;
    logic        rdy_flag;
    logic        rqs;
    logic        clr;
    logic        q_valid;
    logic        q_ready;
    logic [8:0]  q_data;
    logic        pop;
    logic [7:0]  ch;
    logic        is_dig;
    logic [3:0]  lidx;
    logic        close_ok;
    logic        close_bad;
    logic        close_num;
    logic        run_ok;
    logic        run_err;
    logic        poll_drive;
    logic [7:0]  stb;
    logic [19:0] acc10;
    logic        err_evt;

    // map a character to its priority index
    function automatic logic [3:0] letter_idx(input logic [7:0] c);
        letter_idx = gcp_pkg::IX_NONE;
        for (int i = 0; i < gcp_pkg::NCMD; i++) begin
            if (c == gcp_pkg::CMD_CHAR[i]) begin
                letter_idx = 4'(i);
            end
        end
    endfunction

    // legal option for a non-value letter
    function automatic logic opt_legal(input logic [3:0] ix, input logic [15:0] v);
        if (ix == gcp_pkg::IX_GATE) begin
            opt_legal = v == 16'h0000 || v == gcp_pkg::GATE_DONE ||
                        v == gcp_pkg::GATE_RDY || v == gcp_pkg::GATE_ERR;
        end else begin
            opt_legal = v <= {8'h00, gcp_pkg::OPT_MAX[ix]};
        end
    endfunction

    // ==========================================================
    // byte intake: data only, ATN false and listener; tag REN state
    assign clr = reset || (sdc_cmd && listen_addr);
    gcp_fifo #(.WIDTH(9), .DEPTH(16)) u_fifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .flush    (clr),
        .in_valid (rx_valid && !atn && listen_addr),
        .in_ready (rx_ready),
        .in_data  ({!ren, rx_byte}),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data (q_data)
    );

    // ==========================================================
    // character decode and close of the current command
    assign q_ready = st == ST_RX;
    assign pop     = q_valid && q_ready;
    assign ch      = q_data[7:0];
    assign is_dig  = ch >= gcp_pkg::CH_ZERO && ch <= gcp_pkg::CH_NINE;
    assign lidx    = letter_idx(ch);
    assign acc10   = {4'h0, acc} * 20'd10 + {16'h0000, ch[3:0]};

    always_comb begin
        close_ok  = 1'b0;
        close_bad = 1'b0;
        close_num = 1'b0;
        if (cur != gcp_pkg::IX_NONE) begin
            if (cur == gcp_pkg::IX_CAL || cur == gcp_pkg::IX_LCAL || cur == gcp_pkg::IX_OUT) begin
                // value commands: out of range drops only this one
                if (got_dig && !ovf && acc <= (cur == gcp_pkg::IX_OUT ? OUT_MAX : CAL_MAX)) begin
                    close_ok = 1'b1;
                end else begin
                    close_num = 1'b1;
                end
            end else if (got_dig && !ovf && opt_legal(cur, acc)) begin
                close_ok = 1'b1;
            end else begin
                close_bad = 1'b1;
            end
        end
    end

    assign run_err = bad_let || bad_opt || ren_bad || close_bad || q_data[8];
    assign run_ok  = pop && ch == gcp_pkg::CH_RUN && !run_err;

    // ==========================================================
    // string parser: letter then decimal digits, spaces skipped
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            cur     <= gcp_pkg::IX_NONE;
            acc     <= '0;
            got_dig <= 1'b0;
            ovf     <= 1'b0;
            bad_let <= 1'b0;
            bad_opt <= 1'b0;
            bad_num <= 1'b0;
            ren_bad <= 1'b0;
            pend_v  <= '0;
        end else if (pop) begin
            ren_bad <= ren_bad || q_data[8];
            if (ch == gcp_pkg::CH_SPACE) begin
                cur <= cur;
            end else if (is_dig && cur != gcp_pkg::IX_NONE) begin
                acc     <= acc10[15:0];
                ovf     <= ovf || acc10[19:16] != 4'h0;
                got_dig <= 1'b1;
            end else if (ch == gcp_pkg::CH_RUN) begin
                // end of string: letter, option or REN errors discard the whole buffer; a bad value does not
                cur     <= gcp_pkg::IX_NONE;
                bad_let <= 1'b0;
                bad_opt <= 1'b0;
                bad_num <= 1'b0;
                ren_bad <= 1'b0;
                if (run_err) begin
                    pend_v <= '0;
                end else if (close_ok) begin
                    pend[cur]   <= acc;
                    pend_v[cur] <= 1'b1;
                end
            end else begin
                if (close_ok) begin
                    pend[cur]   <= acc;
                    pend_v[cur] <= 1'b1;
                end
                bad_opt <= bad_opt || close_bad;
                bad_num <= bad_num || close_num;
                bad_let <= bad_let || lidx == gcp_pkg::IX_NONE;
                cur     <= lidx;
                acc     <= '0;
                got_dig <= 1'b0;
                ovf     <= 1'b0;
            end
        end else if (st == ST_EXEC && step == gcp_pkg::IX_LAST) begin
            pend_v <= '0;
        end
    end

    // ==========================================================
    // execution sequencer walks the priority order
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            st   <= ST_RX;
            step <= '0;
        end else begin
            case (st)
                ST_RX: begin
                    if (run_ok) begin
                        st   <= ST_EXEC;
                        step <= '0;
                    end
                end
                ST_EXEC: begin
                    step <= step + 1'b1;
                    if (step == gcp_pkg::IX_LAST) begin
                        st <= ST_RX;
                    end
                end
                default: st <= ST_RX;
            endcase
        end
    end

    // settings applied one per step
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            for (int i = 0; i < gcp_pkg::NCMD; i++) begin
                set_reg[i] <= gcp_pkg::DEF_SET;
            end
            self_test <= 1'b0;
            exec_done <= 1'b0;
        end else begin
            self_test <= 1'b0;
            exec_done <= st == ST_EXEC && step == gcp_pkg::IX_LAST;
            if (st == ST_EXEC && pend_v[step]) begin
                set_reg[step] <= pend[step];
                self_test     <= step == gcp_pkg::IX_SELF;
            end
        end
    end

    // setting outputs straight from the setting flops
    assign src_kind      = set_reg[0][2:0];
    assign span_sel      = set_reg[1][3:0];
    assign null_on       = set_reg[2][0];
    assign temp_adj      = set_reg[3][0];
    assign shield_on     = set_reg[4][0];
    assign report_sel    = set_reg[6][1:0];
    assign end_flag_off  = set_reg[7][0];
    assign srq_gate      = set_reg[8][5:0];
    assign cal_value     = set_reg[9];
    assign low_cal_value = set_reg[10];
    assign set_point     = set_reg[11];
    assign prefix_off    = set_reg[12][0];
    assign arm_on        = set_reg[13][0];
    assign line_end      = set_reg[14][2:0];

    // ==========================================================
    // error pulses at the run character, remote state
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            unknown_command_letter <= 1'b0;
            invalid_command_option <= 1'b0;
            number_err             <= 1'b0;
            bus_err                <= 1'b0;
            remote                 <= 1'b0;
        end else begin
            unknown_command_letter <= pop && ch == gcp_pkg::CH_RUN && bad_let;
            invalid_command_option <= pop && ch == gcp_pkg::CH_RUN && (bad_opt || close_bad);
            number_err             <= pop && ch == gcp_pkg::CH_RUN && (bad_num || close_num);
            bus_err                <= pop && ch == gcp_pkg::CH_RUN && (ren_bad || q_data[8]);
            remote                 <= ren && (remote || listen_addr || talk_addr);
        end
    end

    // ==========================================================
    // serial poll mode and status byte drive
    assign poll_drive = spoll && talk_addr && !atn;
    assign stb        = {1'b0, rqs, err_flag, rdy_flag, 4'h0};

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            spoll   <= 1'b0;
            dio_oe  <= 1'b0;
            dio_out <= '0;
        end else begin
            if (spe_cmd) begin
                spoll <= 1'b1;
            end else if (spd_cmd) begin
                spoll <= 1'b0;
            end
            dio_oe  <= poll_drive;
            dio_out <= poll_drive ? stb : 8'h00;
        end
    end

    // sticky error/ready and service request; a new event beats the poll clear
    // request follows a fresh error event, so an old sticky error cannot re-arm it after the poll
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            err_flag <= 1'b0;
            err_evt  <= 1'b0;
            rdy_flag <= 1'b0;
            rqs      <= 1'b0;
            srq      <= 1'b0;
        end else begin
            err_evt  <= unknown_command_letter || invalid_command_option || number_err || bus_err;
            if (unknown_command_letter || invalid_command_option || number_err || bus_err) begin
                err_flag <= 1'b1;
            end else if (dio_oe && !poll_drive) begin
                err_flag <= 1'b0;
            end
            rdy_flag <= exec_done || (rdy_flag && !(dio_oe && !poll_drive));
            if ((err_evt && srq_gate == gcp_pkg::GATE_ERR[5:0]) ||
                (exec_done && srq_gate == gcp_pkg::GATE_RDY[5:0]) ||
                (charge_done && srq_gate == gcp_pkg::GATE_DONE[5:0])) begin
                rqs <= 1'b1;
            end else if (dio_oe && !poll_drive) begin
                rqs <= 1'b0;
            end
            srq <= rqs;
        end
    end

    // ==========================================================
    // checks
    sequence s_run_ok;
        run_ok && st == ST_RX;
    endsequence
    sequence s_walk;
        st == ST_EXEC && step == 4'h0 ##14 st == ST_EXEC && step == 4'hE ##1 st == ST_RX;
    endsequence

    a_exec_walk: assert property (@(posedge sys_clk) disable iff (clr)
        s_run_ok |=> s_walk) else $error("run did not walk all steps");
    a_exec_order: assert property (@(posedge sys_clk) disable iff (clr)
        st == ST_EXEC && step != 4'hE |=> step == $past(step) + 4'h1) else $error("step skipped");
    a_sdc_default: assert property (@(posedge sys_clk) disable iff (reset)
        sdc_cmd && listen_addr |=> src_kind == 3'h0 && line_end == 3'h0 && st == ST_RX)
        else $error("clear left settings");
    a_poll_drive: assert property (@(posedge sys_clk) disable iff (clr)
        poll_drive |=> dio_oe && dio_out == $past(stb)) else $error("status byte not driven");
    a_poll_atn: assert property (@(posedge sys_clk) disable iff (clr)
        atn |=> !dio_oe) else $error("drive while ATN true");
    a_poll_any: assert property (@(posedge sys_clk) disable iff (clr)
        poll_drive && !rqs |=> dio_oe) else $error("poll ignored without request");
    a_atn_block: assert property (@(posedge sys_clk) disable iff (clr)
        rx_valid && atn && !q_valid |=> !q_valid) else $error("byte taken under ATN");
    a_ren_ignore: assert property (@(posedge sys_clk) disable iff (clr)
        pop && ch == gcp_pkg::CH_RUN && q_data[8] |=> bus_err && st == ST_RX && pend_v == '0)
        else $error("REN false string not ignored");
    a_err_srq: assert property (@(posedge sys_clk) disable iff (clr)
        bus_err && srq_gate == 6'h20 |=> err_flag ##1 rqs ##1 srq) else $error("error did not request");
endmodule

// ==== dv/gcp_ctl_model.sv ====
// controller model: listener, clear and poll sequences toward the parser
`timescale 1ns/100ps

module gcp_ctl_model (
    // clock
    input  wire logic       sys_clk,
    // bus state toward the device
    output logic            atn,
    output logic            ren,
    output logic            listen_addr,
    output logic            talk_addr,
    output logic            sdc_cmd,
    output logic            spe_cmd,
    output logic            spd_cmd,
    // data bytes
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    input  wire logic       rx_ready,
    // status byte from the device
    input  wire logic [7:0] dio_out,
    input  wire logic       dio_oe
);
    // ==========================================================
    // idle: attention held, nothing addressed, enable low
    initial begin
        atn = 1'b1;
        ren = 1'b0;
        listen_addr = 1'b0;
        talk_addr = 1'b0;
        sdc_cmd = 1'b0;
        spe_cmd = 1'b0;
        spd_cmd = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end

    // remote enable line level
    task automatic set_ren(input logic v);
        ren = v;
    endtask

    // next edge plus drive delay
    task automatic step();
        @(posedge sys_clk);
        #2;
    endtask

    // address as listener, release attention, one byte per accepted edge
    task automatic send(input string s, input logic keep_atn);
        int n;
        atn = 1'b1;
        listen_addr = 1'b1;
        step();
        atn = keep_atn;
        step();
        for (int i = 0; i < s.len(); i++) begin
            rx_byte = s[i];
            rx_valid = 1'b1;
            n = 0;
            @(negedge sys_clk);
            while (rx_ready !== 1'b1 && n < 200) begin
                @(negedge sys_clk);
                n++;
            end
            step();
        end
        rx_valid = 1'b0;
        rx_byte = ~rx_byte; // released lines must not hold the last byte
        atn = 1'b1;
        listen_addr = 1'b0;
    endtask

    // selective clear: attention, listen address, clear byte
    task automatic clear();
        atn = 1'b1;
        listen_addr = 1'b1;
        step();
        sdc_cmd = 1'b1;
        step();
        sdc_cmd = 1'b0;
        listen_addr = 1'b0;
    endtask

    // poll mode on and off under attention
    task automatic poll_on();
        atn = 1'b1;
        spe_cmd = 1'b1;
        step();
        spe_cmd = 1'b0;
    endtask

    task automatic poll_off();
        spd_cmd = 1'b1;
        step();
        spd_cmd = 1'b0;
    endtask

    // talk address under attention, status read with attention false
    task automatic poll_read(output logic [7:0] sb, output logic oe);
        talk_addr = 1'b1;
        step();
        atn = 1'b0;
        step();
        step();
        @(negedge sys_clk);
        sb = dio_out;
        oe = dio_oe;
        step();
        atn = 1'b1;
        talk_addr = 1'b0;
        step();
    endtask
endmodule

// ==== dv/gcp_parser_test.sv ====
// testbench: command strings, clear and poll sequences against the parser
`timescale 1ns/100ps

module gcp_parser_test;
    // ==========================================================
    // clock, reset and observed signals
    logic        sys_clk = 1'b0;
    logic        reset;
    logic        atn, ren, listen_addr, talk_addr, sdc_cmd, spe_cmd, spd_cmd;
    logic        rx_valid, rx_ready, dio_oe, srq, charge_done;
    logic [7:0]  rx_byte, dio_out, sb;
    logic [2:0]  src_kind, line_end;
    logic [3:0]  span_sel;
    logic [1:0]  report_sel;
    logic [5:0]  srq_gate;
    logic [15:0] cal_value, low_cal_value, set_point;
    logic        null_on, temp_adj, shield_on, self_test, end_flag_off, prefix_off, arm_on;
    logic        remote, unknown_command_letter, invalid_command_option, number_err, bus_err;
    logic        exec_done, oe;
    logic [5:0]  seen;
    int          n_errors = 0;
    int          compares = 0;
    int          n_full = 0;

    always #12.5 sys_clk = ~sys_clk;

    gcp_ctl_model u_ctl (.sys_clk(sys_clk), .atn(atn), .ren(ren), .listen_addr(listen_addr),
        .talk_addr(talk_addr), .sdc_cmd(sdc_cmd), .spe_cmd(spe_cmd), .spd_cmd(spd_cmd),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready), .dio_out(dio_out), .dio_oe(dio_oe));

    gcp_parser u_dut (.sys_clk(sys_clk), .reset(reset), .atn(atn), .ren(ren), .listen_addr(listen_addr),
        .talk_addr(talk_addr), .sdc_cmd(sdc_cmd), .spe_cmd(spe_cmd), .spd_cmd(spd_cmd),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready), .dio_out(dio_out), .dio_oe(dio_oe),
        .srq(srq), .charge_done(charge_done), .src_kind(src_kind), .span_sel(span_sel),
        .null_on(null_on), .temp_adj(temp_adj), .shield_on(shield_on), .self_test(self_test),
        .report_sel(report_sel), .end_flag_off(end_flag_off), .srq_gate(srq_gate),
        .cal_value(cal_value), .low_cal_value(low_cal_value), .set_point(set_point),
        .prefix_off(prefix_off), .arm_on(arm_on), .line_end(line_end), .remote(remote),
        .unknown_command_letter(unknown_command_letter), .invalid_command_option(invalid_command_option),
        .number_err(number_err), .bus_err(bus_err), .exec_done(exec_done));

    // sticky copies of the one-cycle indications, refusal count
    always @(posedge sys_clk) begin
        seen <= seen | {self_test, bus_err, number_err, invalid_command_option, unknown_command_letter, exec_done};
        if (rx_ready === 1'b0)
            n_full <= n_full + 1;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic wait_cy(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask

    // send one string, wait for the run sequence under a bound
    task automatic run(input string s, input logic keep_atn);
        int n;
        seen = 6'h00;
        u_ctl.send(s, keep_atn);
        n = 0;
        while (seen[0] !== 1'b1 && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        wait_cy(4);
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        end_of_test();
    end

    // ==========================================================
    // test sequence
    initial begin
        reset = 1'b1;
        charge_done = 1'b0;
        seen = 6'h00;
        wait_cy(10);
        reset = 1'b0;
        wait_cy(1);
        chk({src_kind, span_sel, srq, dio_oe, remote, rx_ready}, 11'h001);
        u_ctl.poll_on();
        u_ctl.poll_read(sb, oe);
        chk({oe, sb[6]}, 2'h2);
        u_ctl.poll_off();
        u_ctl.set_ren(1'b1);
        wait_cy(4);
        chk(remote, 1'b0);
        run("F5R3", 1'b0);
        chk(src_kind, 3'h0);
        chk(remote, 1'b1);
        run("X", 1'b0);
        chk({src_kind, span_sel}, 7'h53);
        run("F1F4F6 Z1 W1X", 1'b0);
        chk({src_kind, null_on, shield_on}, 5'h1B);
        run("O1G1K1J0C1X", 1'b0);
        chk({seen[5], temp_adj, end_flag_off, prefix_off, arm_on}, 5'h1F);
        for (int i = 0; i < 13; i++) begin
            run($sformatf("R%0dX", i), 1'b0);
            chk(span_sel, i[3:0]);
        end
        for (int i = 0; i < 5; i++) begin
            run($sformatf("Y%0dX", i), 1'b0);
            chk(line_end, i[2:0]);
        end
        for (int i = 0; i < 3; i++) begin
            run($sformatf("U%0dX", i), 1'b0);
            chk(report_sel, i[1:0]);
        end
        for (int i = 0; i < 8; i++) begin
            run($sformatf("F%0dX", i), 1'b0);
            chk(src_kind, i[2:0]);
        end
        run("F2E1X", 1'b0);
        chk({seen[1], src_kind}, 4'hF);
        run("R2F9X", 1'b0);
        chk({seen[2], src_kind, span_sel}, 8'hFC);
        run("F0X", 1'b1);
        chk(src_kind, 3'h7);
        u_ctl.set_ren(1'b0);
        run("F0X", 1'b0);
        chk({seen[4], src_kind}, 4'hF);
        u_ctl.set_ren(1'b1);
        run("L123A5V100X", 1'b0);
        chk({low_cal_value, set_point}, {16'h007B, 16'h0064});
        chk(cal_value, 16'h0005);
        run("V10000Z0X", 1'b0);
        chk({seen[3], set_point, null_on}, {1'b1, 16'h0064, 1'b0});
        run("M32X", 1'b0);
        chk(srq_gate, 6'h20);
        run("E1X", 1'b0);
        chk(srq, 1'b1);
        u_ctl.poll_on();
        u_ctl.poll_read(sb, oe);
        chk({oe, sb[6:5]}, 3'h7);
        u_ctl.poll_read(sb, oe);
        chk({oe, sb[6], srq}, 3'h4);
        u_ctl.poll_off();
        n_full = 0;
        run("F1X                        ", 1'b0);
        chk({n_full != 0, rx_ready, src_kind}, 5'h19);
        u_ctl.clear();
        wait_cy(2);
        chk({src_kind, span_sel, null_on, shield_on, line_end, srq_gate}, 18'h00000);
        chk({set_point, temp_adj, arm_on}, 18'h00000);
        end_of_test();
    end
endmodule
